/* strap_cfg_regs.vh */
`ifndef STRAP_CFG_REGS_VH
`define STRAP_CFG_REGS_VH

// I/O port pair: index port and data port
`define IO_INDEX_PORT 16'h0022
`define IO_DATA_PORT 16'h0023

// Register indexes
`define IDX_STRAP_CAPTURE_ONE 8'h4B
`define IDX_STRAP_CAPTURE_TWO 8'h4C
`define IDX_HOST_CLOCK_STRAP 8'h4D

// Field positions
`define SC1_SPARE_LSB 2
`define SC2_CORE_MULT_BIT 7
`define SC2_DOT_SRC_BIT 4
`define HCS_CODE_LSB 3

// Reset values before capture and for unmapped indexes
`define STRAP_RESET_VAL 8'h00
`define IDX_RESET_VAL 8'h00
`define UNMAPPED_RD_VAL 8'h00

// Cycles after reset release before the straps are latched
`define STRAP_SETTLE_CYCLES 4'h4

// Host clock rates in MHz
`define HCLK_MHZ_0 7'h19
`define HCLK_MHZ_1 7'h32
`define HCLK_MHZ_2 7'h3C
`define HCLK_MHZ_3 7'h42
`define HCLK_MHZ_4 7'h4B
`define HCLK_MHZ_5 7'h5A
`define HCLK_MHZ_6 7'h64

`endif

/* strap_sync.v */
module strap_sync #(
   parameter WIDTH = 11
) (
   input wire core_clk_i,
   input wire rst_i,
   input wire [WIDTH-1:0] pins_i,
   output wire [WIDTH-1:0] stage2_o,
   output wire [WIDTH-1:0] stage3_o
);

   reg [WIDTH-1:0] s1_r;
   reg [WIDTH-1:0] s2_r;
   reg [WIDTH-1:0] s3_r;

   // First stage feeds only the second
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_r <= {WIDTH{1'b0}};
         s2_r <= {WIDTH{1'b0}};
         s3_r <= {WIDTH{1'b0}};
      end else begin
         s1_r <= pins_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign stage2_o = s2_r;
   assign stage3_o = s3_r;

endmodule

/* strap_config_registers.v */
`include "strap_cfg_regs.vh"

// Operation
// - Index port 0022h, data port 0023h; index 04Bh is reg 1, 04Ch reg 2.
// - Register 1 bits 5 to 2 hold the spare strap levels; no function.
// - Register 2 and host clock register load the straps caught at reset.
// - Register 2 bit 7 shows the multiplier strap: 0 is 1x, 1 is 2x.
// - Register 2 bit 4 picks the dot clock: 0 pin is input, 1 pin drives.
// - Software may read the dot clock source bit at any time, and write it once the straps are caught.
// - Host clock register bits 7 to 3 hold pins 3, 2, 26, 25, 24 in order.
// - The low 3 bits of the host clock code pick 25, 50, 60, 66, 75, 90 or 100 MHz.
// - Register 2 bits 6-5, 3, 2, 1 and 0 are reserved and unconnected.
module strap_config_registers (
   input wire core_clk_i,
   input wire rst_i,
   input wire [3:0] spare_strap_pins_i,
   input wire core_multiplier_strap_i,
   input wire dot_clock_source_strap_i,
   input wire [1:0] host_speed_strap_high_i,
   input wire [2:0] host_speed_strap_low_i,
   input wire [15:0] io_addr_i,
   input wire io_wr_i,
   input wire io_rd_i,
   input wire [7:0] io_wdata_i,
   output reg [7:0] io_rdata_o,
   output reg strap_ready_o,
   output reg core_mult_2x_o,
   output reg pixel_dot_clock_oe_o,
   output reg [4:0] host_clock_code_o,
   output reg [6:0] host_clock_mhz_o
);

   localparam NPINS = 11;
   localparam ST_SETTLE = 2'b01;
   localparam ST_HELD = 2'b10;
   // Slots of the straps in the synchronised vector
   localparam PIN_SPARE_LSB = 7;
   localparam PIN_CORE_MULT = 6;
   localparam PIN_DOT_SRC = 5;
   localparam PIN_HCLK_LSB = 0;
   localparam SPARE_W = 4;
   localparam HCLK_W = 5;

   ////////////////////////////////////////////////////////////////////////

   wire [NPINS-1:0] pins;
   wire [NPINS-1:0] sync2;
   wire [NPINS-1:0] sync3;
   wire [NPINS-1:0] agree;
   wire all_agree;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [3:0] settle_r;
   reg [3:0] settle_nxt;
   reg [7:0] index_r;
   reg [3:0] spare_r;
   reg [3:0] spare_nxt;
   reg core_mult_r;
   reg core_mult_nxt;
   reg dot_src_r;
   reg dot_src_nxt;
   reg [4:0] hclk_code_r;
   reg [4:0] hclk_code_nxt;
   reg ready_nxt;
   reg [7:0] rd_mux;
   wire index_wr;
   wire index_rd;
   wire data_wr;
   wire data_rd;

   // One decoder for both ports
   function port_hit;
      input [15:0] addr;
      input [15:0] port;
      begin
         port_hit = (addr == port);
      end
   endfunction

   assign pins = {spare_strap_pins_i, core_multiplier_strap_i,
                  dot_clock_source_strap_i, host_speed_strap_high_i,
                  host_speed_strap_low_i};
   assign index_wr = io_wr_i && port_hit(io_addr_i, `IO_INDEX_PORT);
   assign index_rd = io_rd_i && port_hit(io_addr_i, `IO_INDEX_PORT);
   assign data_wr = io_wr_i && port_hit(io_addr_i, `IO_DATA_PORT);
   assign data_rd = io_rd_i && port_hit(io_addr_i, `IO_DATA_PORT);

   strap_sync #(
      .WIDTH(NPINS)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pins_i(pins),
      .stage2_o(sync2),
      .stage3_o(sync3)
   );

   // Per-pin agreement of the last two stages; a pin still moving blocks
   // the latch, so a level that changed in the last cycle is not caught
   genvar g;
   generate
      for (g = 0; g < NPINS; g = g + 1) begin : g_agree
         assign agree[g] = ~(sync2[g] ^ sync3[g]);
      end
   endgenerate
   assign all_agree = &agree;

   // Mapping of host clock code to MHz from its low 3 bits; low value 7 falls to 66
   function [6:0] hclk_mhz;
      input [4:0] code;
      begin
         case (code[2:0])
            3'h0: hclk_mhz = `HCLK_MHZ_0;
            3'h1: hclk_mhz = `HCLK_MHZ_1;
            3'h2: hclk_mhz = `HCLK_MHZ_2;
            3'h3: hclk_mhz = `HCLK_MHZ_3;
            3'h4: hclk_mhz = `HCLK_MHZ_4;
            3'h5: hclk_mhz = `HCLK_MHZ_5;
            3'h6: hclk_mhz = `HCLK_MHZ_6;
            default: hclk_mhz = `HCLK_MHZ_3;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Strap capture: waits out the synchroniser, then latches once

   always @* begin
      state_nxt = state_r;
      settle_nxt = settle_r;
      spare_nxt = spare_r;
      core_mult_nxt = core_mult_r;
      dot_src_nxt = dot_src_r;
      hclk_code_nxt = hclk_code_r;
      ready_nxt = strap_ready_o;
      case (state_r)
         ST_SETTLE: begin
            if (settle_r != `STRAP_SETTLE_CYCLES) begin
               settle_nxt = settle_r + 4'h1;
            end else if (all_agree) begin
               spare_nxt = sync3[PIN_SPARE_LSB +: SPARE_W];
               core_mult_nxt = sync3[PIN_CORE_MULT];
               dot_src_nxt = sync3[PIN_DOT_SRC];
               hclk_code_nxt = sync3[PIN_HCLK_LSB +: HCLK_W];
               ready_nxt = 1'b1;
               state_nxt = ST_HELD;
            end
         end
         ST_HELD: begin
            // Only bit 4 of register 2 takes a write; the rest is dropped
            if (data_wr && index_r == `IDX_STRAP_CAPTURE_TWO) begin
               dot_src_nxt = io_wdata_i[`SC2_DOT_SRC_BIT];
            end
         end
         default: state_nxt = ST_SETTLE;
      endcase
   end

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_SETTLE;
         settle_r <= 4'h0;
         spare_r <= 4'h0;
         core_mult_r <= 1'b0;
         dot_src_r <= 1'b0;
         hclk_code_r <= 5'h00;
         strap_ready_o <= 1'b0;
      end else begin
         state_r <= state_nxt;
         settle_r <= settle_nxt;
         spare_r <= spare_nxt;
         core_mult_r <= core_mult_nxt;
         dot_src_r <= dot_src_nxt;
         hclk_code_r <= hclk_code_nxt;
         strap_ready_o <= ready_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Index port and read path

   always @* begin
      rd_mux = `UNMAPPED_RD_VAL;
      case (index_r)
         `IDX_STRAP_CAPTURE_ONE: begin
            rd_mux[`SC1_SPARE_LSB +: SPARE_W] = spare_r;
         end
         `IDX_STRAP_CAPTURE_TWO: begin
            rd_mux[`SC2_CORE_MULT_BIT] = core_mult_r;
            rd_mux[`SC2_DOT_SRC_BIT] = dot_src_r;
         end
         `IDX_HOST_CLOCK_STRAP: begin
            rd_mux[`HCS_CODE_LSB +: HCLK_W] = hclk_code_r;
         end
         default: rd_mux = `UNMAPPED_RD_VAL;
      endcase
   end

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         index_r <= `IDX_RESET_VAL;
         io_rdata_o <= `STRAP_RESET_VAL;
         core_mult_2x_o <= 1'b0;
         pixel_dot_clock_oe_o <= 1'b0;
         host_clock_code_o <= 5'h00;
         host_clock_mhz_o <= 7'h00;
      end else begin
         if (index_wr) begin
            index_r <= io_wdata_i;
         end
         // Read data holds until the next port read
         if (data_rd) begin
            io_rdata_o <= rd_mux;
         end else if (index_rd) begin
            io_rdata_o <= index_r;
         end
         // Outputs held low until straps are caught, so no false drive
         core_mult_2x_o <= core_mult_r;
         pixel_dot_clock_oe_o <= dot_src_r & strap_ready_o;
         host_clock_code_o <= hclk_code_r;
         host_clock_mhz_o <= strap_ready_o ? hclk_mhz(hclk_code_r)
                                           : 7'h00;
      end
   end

endmodule

/* strap_cfg_monitor.sv */
module strap_cfg_monitor (
   input wire core_clk_i,
   input wire rst_i,
   input wire [15:0] io_addr_i,
   input wire io_wr_i,
   input wire io_rd_i,
   input wire [7:0] io_wdata_i,
   input wire [7:0] io_rdata_o,
   input wire strap_ready_o,
   input wire core_mult_2x_o,
   input wire pixel_dot_clock_oe_o,
   input wire [4:0] host_clock_code_o,
   input wire [6:0] host_clock_mhz_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam [55:0] MHZ = {7'h42, 7'h64, 7'h5A, 7'h4B, 7'h42, 7'h3C, 7'h32,
      7'h19};
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   a_ready_time: assert property (
      $fell(rst_i) |-> !strap_ready_o[*5] ##1 strap_ready_o)
      else $error("ready");
   a_ready_stay: assert property (
      strap_ready_o |=> strap_ready_o) else $error("ready fell");
   a_capture_hold: assert property (
      strap_ready_o && $past(strap_ready_o, 2)
      |-> $stable({core_mult_2x_o, host_clock_code_o}))
      else $error("resample");
   a_mhz_map: assert property (
      strap_ready_o && $past(strap_ready_o)
      |-> host_clock_mhz_o == MHZ[host_clock_code_o[2:0]*7 +: 7])
      else $error("mhz");
   a_idle_before: assert property (
      !strap_ready_o |-> !pixel_dot_clock_oe_o && host_clock_mhz_o == 7'h00)
      else $error("early drive");
   a_rdata_hold: assert property (
      !io_rd_i |=> $stable(io_rdata_o)) else $error("rdata moved");
   a_other_addr: assert property (
      io_rd_i && io_addr_i[15:1] != 15'h0011 |=> $stable(io_rdata_o))
      else $error("foreign read");
   a_index_echo: assert property (
      io_wr_i && io_addr_i == 16'h0022 ##1 io_rd_i && io_addr_i == 16'h0022
      |=> io_rdata_o == $past(io_wdata_i, 2)) else $error("index echo");
   c_ready: cover property ($rose(strap_ready_o));
   c_drive: cover property (strap_ready_o && pixel_dot_clock_oe_o);
   c_data: cover property (io_rd_i && io_addr_i == 16'h0023);
endmodule
bind strap_config_registers strap_cfg_monitor mon (.*);

/* strap_board.sv */
module strap_board (
   input wire core_clk_i,
   input wire busy_i,
   input wire [10:0] level_i,
   output logic [10:0] pins_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pins toggle every cycle after capture, so a late resample shows up
   always @(posedge core_clk_i) begin
      if (busy_i) pins_o <= ~pins_o;
      else pins_o <= level_i;
   end
endmodule

/* tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_i = 1'b0, rst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0;
   logic [15:0] io_addr_i = 16'h0000;
   logic [7:0] io_wdata_i = 8'h00;
   logic [10:0] lv = 11'h000;
   wire [10:0] pn;
   wire [7:0] io_rdata_o;
   wire rdy, mult, oe;
   wire [4:0] code;
   wire [6:0] mhz;
   int errors = 0, samples_checked = 0;
   localparam [55:0] MHZ = {7'h42, 7'h64, 7'h5A, 7'h4B, 7'h42, 7'h3C, 7'h32,
      7'h19};
   strap_board board (.core_clk_i(core_clk_i), .busy_i(rdy), .level_i(lv),
      .pins_o(pn));
   strap_config_registers DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .spare_strap_pins_i(pn[3:0]), .core_multiplier_strap_i(pn[4]),
      .dot_clock_source_strap_i(pn[5]), .host_speed_strap_high_i(pn[7:6]),
      .host_speed_strap_low_i(pn[10:8]), .io_addr_i(io_addr_i),
      .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
      .io_rdata_o(io_rdata_o), .strap_ready_o(rdy), .core_mult_2x_o(mult),
      .pixel_dot_clock_oe_o(oe), .host_clock_code_o(code),
      .host_clock_mhz_o(mhz));
   initial forever #25 core_clk_i = ~core_clk_i;
   initial begin
      #200000;
      errors++;
      give_verdict;
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task io(input logic w, input [15:0] a, input [7:0] d);
      @(posedge core_clk_i);
      io_wr_i <= w;
      io_rd_i <= !w;
      io_addr_i <= a;
      io_wdata_i <= d;
      @(posedge core_clk_i);
      io_wr_i <= 1'b0;
      io_rd_i <= 1'b0;
   endtask
   // Extra edge: data stands until the next read anyway
   task rd(input [7:0] idx, input [7:0] e, input string nm);
      io(1'b1, 16'h0022, idx);
      io(1'b0, 16'h0023, 8'h00);
      @(posedge core_clk_i);
      #1 chk(nm, e, io_rdata_o);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task run_straps(input [10:0] p);
      @(posedge core_clk_i);
      lv <= p;
      rst_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      #1 chk("ready", 8'h01, {7'h00, rdy});
      chk("mult", {7'h00, p[4]}, {7'h00, mult});
      chk("oe", {7'h00, p[5]}, {7'h00, oe});
      chk("code", {3'h0, p[7:6], p[10:8]}, {3'h0, code});
      chk("mhz", {1'b0, MHZ[p[10:8]*7 +: 7]}, {1'b0, mhz});
      rd(8'h4B, {2'b00, p[3:0], 2'b00}, "one");
      rd(8'h4C, {p[4], 2'b00, p[5], 4'h0}, "two");
      rd(8'h4D, {p[7:6], p[10:8], 3'h0}, "host");
   endtask
   task write_dot;
      io(1'b1, 16'h0022, 8'h4C);
      io(1'b1, 16'h0023, 8'h00);
      rd(8'h4C, 8'h00, "dot off");
      chk("oe off", 8'h00, {7'h00, oe});
      io(1'b1, 16'h0023, 8'hFF);
      rd(8'h4C, 8'h10, "dot on");
      chk("oe on", 8'h01, {7'h00, oe});
      io(1'b1, 16'h0022, 8'h4B);
      io(1'b1, 16'h0023, 8'hCF);
      io(1'b1, 16'h0030, 8'h4D);
      io(1'b0, 16'h0023, 8'h00);
      @(posedge core_clk_i);
      #1 chk("one kept", 8'h30, io_rdata_o);
      io(1'b0, 16'h0031, 8'h00);
      @(posedge core_clk_i);
      #1 chk("foreign rd", 8'h30, io_rdata_o);
      io(1'b1, 16'h0022, 8'h4D);
      io(1'b1, 16'h0023, 8'h07);
      rd(8'h4D, 8'hF8, "host kept");
      @(posedge core_clk_i);
      io_wr_i <= 1'b1;
      io_addr_i <= 16'h0022;
      io_wdata_i <= 8'h4E;
      @(posedge core_clk_i);
      io_wr_i <= 1'b0;
      io_rd_i <= 1'b1;
      @(posedge core_clk_i);
      io_rd_i <= 1'b0;
      @(posedge core_clk_i);
      #1 chk("index", 8'h4E, io_rdata_o);
      rd(8'h4E, 8'h00, "unmapped");
   endtask
   task give_verdict;
      if (errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 8; i++) begin
         run_straps({i[2:0], i[0], i[1], i[2], ~i[0], i[1:0], ~i[1:0]});
      end
      write_dot;
      give_verdict;
   end
endmodule
